// ==== verilog/dbp_port.sv ====
// Direct bit and byte pin port with an APB register slave.
//
// Local design decisions: register access over APB and the placing of the registers.
`timescale 1ns/100ps
// Overview of operation
// - Pin value zero is low, one high.
// - Twelve pins each independently input or output outside byte mode, where pins zero to seven share the direction of pin zero.
// - Direction changes at run time, no reset.
// - Nonzero write value drives the pin high.
// - Sample or drive at request, no latching.
// - Initialisation loads each bit output level.
// - Byte mode uses pins zero to seven.
// - Byte bit zero maps to pin zero.
// - Initialisation loads byte output initial value.
// - Power line variant pull-ups off until requested.
// - Twisted pair self test enables group pull-ups.
// - Bit read samples after 41 or 8.4 us.
// - Bit write updates after 69 or 60 us.
// - Byte read samples after 24 us.
// - Byte write updates after 57 us.
module dbp_port #(
    parameter int BIT_IN_CYC = dbp_pkg::C_BIT_IN,
    parameter int BIT_IN11_CYC = dbp_pkg::C_BIT_IN11,
    parameter int BIT_OUT_SLOW_CYC = dbp_pkg::C_BIT_OUT_SLOW,
    parameter int BIT_OUT_CYC = dbp_pkg::C_BIT_OUT,
    parameter int BYTE_IN_CYC = dbp_pkg::C_BYTE_IN,
    parameter int BYTE_OUT_CYC = dbp_pkg::C_BYTE_OUT
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [11:0] pinIn,
    output dbp_pkg::dbp_pins_t pins
);
    // Every latency counter shares this width.
    localparam int CW = 16;

    // Refuse latencies that the counter cannot hold. The check is made
    // at elaboration, so a bad value never reaches a build or a run.
    if (BIT_IN_CYC < 1 || BIT_IN_CYC >= (1 << CW) ||
        BIT_IN11_CYC < 1 || BIT_IN11_CYC >= (1 << CW) ||
        BIT_OUT_SLOW_CYC < 1 || BIT_OUT_SLOW_CYC >= (1 << CW) ||
        BIT_OUT_CYC < 1 || BIT_OUT_CYC >= (1 << CW) ||
        BYTE_IN_CYC < 1 || BYTE_IN_CYC >= (1 << CW) ||
        BYTE_OUT_CYC < 1 || BYTE_OUT_CYC >= (1 << CW)) begin
        $error("Latency parameter out of counter range.");
    end

    // Operation in flight.
    typedef enum logic [2:0] {
        OP_IDLE = 3'b000,
        OP_BITRD = 3'b001,
        OP_BITWR = 3'b010,
        OP_BYTERD = 3'b011,
        OP_BYTEWR = 3'b100
    } dbp_op_t;

    // Synchronised pin levels.
    logic [11:0] pinSync;
    // Software-visible configuration.
    logic byteMode_ff;
    logic variant_ff;
    logic pullReq_ff;
    logic [11:0] dir_ff;
    logic [11:0] initVal_ff;
    // Output latch and pin enables.
    logic [11:0] outVal_ff;
    logic [11:0] pullEn_ff;
    // Request in flight.
    dbp_op_t op_ff;
    logic [3:0] reqPin_ff;
    logic [7:0] reqVal_ff;
    logic [CW-1:0] cnt_ff;
    // Result of the last read and a done flag.
    logic [7:0] rdVal_ff;
    logic done_ff;
    // APB answer registers.
    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;

    // An access phase is taken in a single cycle.
    logic apbAcc;
    logic apbWr;
    logic busy;
    logic addrOk;
    assign apbAcc = psel && penable && !pready_ff;
    assign apbWr = apbAcc && pwrite;
    assign busy = (op_ff != OP_IDLE);

    // Pin inputs cross into the clock domain through two stages.
    dbp_sync #(
        .WIDTH(dbp_pkg::NUM_PINS)
    ) u_sync (
        .mclk(mclk),
        .rst_n(rst_n),
        .asyncIn(pinIn),
        .syncOut(pinSync)
    );

    // Decode: only the listed offsets answer without error.
    always_comb begin
        unique case (paddr)
            dbp_pkg::OFF_CTRL, dbp_pkg::OFF_DIR, dbp_pkg::OFF_INIT,
            dbp_pkg::OFF_BITREQ, dbp_pkg::OFF_BYTEREQ,
            dbp_pkg::OFF_STATUS, dbp_pkg::OFF_PINS: addrOk = 1'b1;
            default: addrOk = 1'b0;
        endcase
    end

    // Configuration registers; direction may change at any time.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            byteMode_ff <= 1'b0;
            variant_ff <= 1'b0;
            pullReq_ff <= 1'b0;
            dir_ff <= dbp_pkg::DIR_RST;
            initVal_ff <= dbp_pkg::INIT_RST;
        end else if (apbWr) begin
            if (paddr == dbp_pkg::OFF_CTRL) begin
                byteMode_ff <= pwdata[dbp_pkg::CTRL_BYTEMODE];
                variant_ff <= pwdata[dbp_pkg::CTRL_VARIANT];
                pullReq_ff <= pwdata[dbp_pkg::CTRL_PULLREQ];
            end
            if (paddr == dbp_pkg::OFF_DIR) begin
                dir_ff <= pwdata[11:0];
            end
            if (paddr == dbp_pkg::OFF_INIT) begin
                initVal_ff <= pwdata[11:0];
            end
        end
    end

    // Pull-ups: off after reset; the twisted pair variant's self test
    // turns the group on, the power line variant needs a pull request at init.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pullEn_ff <= 12'h000;
        end else if (apbWr && paddr == dbp_pkg::OFF_CTRL &&
                     pwdata[dbp_pkg::CTRL_INITGO]) begin
            if (pwdata[dbp_pkg::CTRL_VARIANT]) begin
                pullEn_ff <= 12'h0f0;
            end else if (pwdata[dbp_pkg::CTRL_PULLREQ]) begin
                pullEn_ff <= 12'h8f0;
            end else begin
                pullEn_ff <= 12'h000;
            end
        end
    end

    // Request capture and latency countdown; a request while busy is
    // refused with pslverr so the pins never see a half-done action.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            op_ff <= OP_IDLE;
            reqPin_ff <= 4'h0;
            reqVal_ff <= 8'h00;
            cnt_ff <= '0;
        end else if (!busy && apbWr &&
                     paddr == dbp_pkg::OFF_BITREQ &&
                     pwdata[3:0] < 4'hc) begin
            reqPin_ff <= pwdata[3:0];
            reqVal_ff <= pwdata[dbp_pkg::BREQ_VAL_LSB +: 8];
            if (pwdata[dbp_pkg::BREQ_WRITE]) begin
                op_ff <= OP_BITWR;
                if (pwdata[3:0] == 4'h3 || pwdata[3:0] == 4'h4 ||
                    pwdata[3:0] == 4'h5 || pwdata[3:0] == 4'hb) begin
                    cnt_ff <= CW'(BIT_OUT_SLOW_CYC - 1);
                end else begin
                    cnt_ff <= CW'(BIT_OUT_CYC - 1);
                end
            end else begin
                op_ff <= OP_BITRD;
                if (pwdata[3:0] == 4'hb) begin
                    cnt_ff <= CW'(BIT_IN11_CYC - 1);
                end else begin
                    cnt_ff <= CW'(BIT_IN_CYC - 1);
                end
            end
        end else if (!busy && apbWr &&
                     paddr == dbp_pkg::OFF_BYTEREQ && byteMode_ff) begin
            reqVal_ff <= pwdata[7:0];
            if (pwdata[dbp_pkg::YREQ_WRITE]) begin
                op_ff <= OP_BYTEWR;
                cnt_ff <= CW'(BYTE_OUT_CYC - 1);
            end else begin
                op_ff <= OP_BYTERD;
                cnt_ff <= CW'(BYTE_IN_CYC - 1);
            end
        end else if (busy) begin
            if (cnt_ff == '0) begin
                op_ff <= OP_IDLE;
            end else begin
                cnt_ff <= cnt_ff - CW'(1);
            end
        end
    end

    // Output latch: initial levels on init, request values at expiry.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            outVal_ff <= 12'h000;
        end else if (apbWr && paddr == dbp_pkg::OFF_CTRL &&
                     pwdata[dbp_pkg::CTRL_INITGO]) begin
            outVal_ff <= initVal_ff;
        end else if (busy && cnt_ff == '0) begin
            if (op_ff == OP_BITWR) begin
                outVal_ff[reqPin_ff] <= (reqVal_ff != 8'h00);
            end else if (op_ff == OP_BYTEWR) begin
                outVal_ff[7:0] <= reqVal_ff;
            end
        end
    end

    // Read result: sampled only at expiry, never earlier.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rdVal_ff <= 8'h00;
            done_ff <= 1'b0;
        end else if (busy && cnt_ff == '0) begin
            done_ff <= 1'b1;
            if (op_ff == OP_BITRD) begin
                rdVal_ff <= {7'h00, pinSync[reqPin_ff]};
            end else if (op_ff == OP_BYTERD) begin
                rdVal_ff <= pinSync[7:0];
            end
        end else if (apbWr && (paddr == dbp_pkg::OFF_BITREQ ||
                               paddr == dbp_pkg::OFF_BYTEREQ)) begin
            done_ff <= 1'b0;
        end
    end

    // APB answer: one wait state, so pready rises the cycle after the
    // access phase opens and read data is registered with it.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h00000000;
        end else if (apbAcc) begin
            pready_ff <= 1'b1;
            pslverr_ff <= !addrOk || (pwrite && busy &&
                (paddr == dbp_pkg::OFF_BITREQ ||
                 paddr == dbp_pkg::OFF_BYTEREQ));
            unique case (paddr)
                dbp_pkg::OFF_CTRL:
                    prdata_ff <= {29'h0, pullReq_ff, variant_ff,
                                  byteMode_ff};
                dbp_pkg::OFF_DIR: prdata_ff <= {20'h0, dir_ff};
                dbp_pkg::OFF_INIT: prdata_ff <= {20'h0, initVal_ff};
                dbp_pkg::OFF_STATUS:
                    prdata_ff <= {22'h0, busy, done_ff, rdVal_ff};
                dbp_pkg::OFF_PINS: prdata_ff <= {20'h0, outVal_ff};
                default: prdata_ff <= 32'h00000000;
            endcase
        end else begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
        end
    end

    // Output enables follow direction; byte mode forces the low byte.
    logic [11:0] oeNxt;
    always_comb begin
        oeNxt = dir_ff;
        if (byteMode_ff) begin
            oeNxt[7:0] = {8{dir_ff[0]}};
        end
    end

    // Register the pin outputs so every top output is a flip-flop.
    logic [11:0] oe_ff;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            oe_ff <= 12'h000;
        end else begin
            oe_ff <= oeNxt;
        end
    end

    assign pins.out = outVal_ff;
    assign pins.oe = oe_ff;
    assign pins.pullEn = pullEn_ff;
    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
endmodule

// ==== inc/dbp_pkg.sv ====
// Package with register map, field layout and timing for the direct pin port.
package dbp_pkg;
    // Register byte offsets.
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_DIR = 8'h04;
    localparam logic [7:0] OFF_INIT = 8'h08;
    localparam logic [7:0] OFF_BITREQ = 8'h0c;
    localparam logic [7:0] OFF_BYTEREQ = 8'h10;
    localparam logic [7:0] OFF_STATUS = 8'h14;
    localparam logic [7:0] OFF_PINS = 8'h18;
    // Control register fields.
    localparam int CTRL_BYTEMODE = 0;
    localparam int CTRL_VARIANT = 1;
    localparam int CTRL_PULLREQ = 2;
    localparam int CTRL_INITGO = 3;
    // Bit request fields: pin index in [3:0], write flag, value in [15:8].
    localparam int BREQ_WRITE = 4;
    localparam int BREQ_VAL_LSB = 8;
    // Byte request fields: write flag at 8, value in [7:0].
    localparam int YREQ_WRITE = 8;
    // Reset values.
    localparam logic [11:0] DIR_RST = 12'h000;
    localparam logic [11:0] INIT_RST = 12'h000;
    // Pin counts.
    localparam int NUM_PINS = 12;
    localparam int BYTE_PINS = 8;
    // Typical latencies in nanoseconds at the reference rate.
    localparam int T_BIT_IN_NS = 41000;
    localparam int T_BIT_IN11_NS = 8400;
    localparam int T_BIT_OUT_SLOW_NS = 69000;
    localparam int T_BIT_OUT_NS = 60000;
    localparam int T_BYTE_IN_NS = 24000;
    localparam int T_BYTE_OUT_NS = 57000;
    localparam int CLK_NS = 4;
    // Cycle counts derived from the times, rounded down, at least one.
    localparam int C_BIT_IN = T_BIT_IN_NS / CLK_NS;
    localparam int C_BIT_IN11 = T_BIT_IN11_NS / CLK_NS;
    localparam int C_BIT_OUT_SLOW = T_BIT_OUT_SLOW_NS / CLK_NS;
    localparam int C_BIT_OUT = T_BIT_OUT_NS / CLK_NS;
    localparam int C_BYTE_IN = T_BYTE_IN_NS / CLK_NS;
    localparam int C_BYTE_OUT = T_BYTE_OUT_NS / CLK_NS;
    // Pin interface toward the outside world.
    typedef struct packed {
        logic [11:0] out;
        logic [11:0] oe;
        logic [11:0] pullEn;
    } dbp_pins_t;
endpackage

// ==== verilog/dbp_sync.sv ====
// Two-stage synchroniser for a bus of pin inputs.
`timescale 1ns/100ps
module dbp_sync #(
    parameter int WIDTH = 12
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);
    // First stage; read only by the second stage.
    logic [WIDTH-1:0] meta_ff;

    // Both stages clear to zero under reset.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            meta_ff <= '0;
            syncOut <= '0;
        end else begin
            meta_ff <= asyncIn;
            syncOut <= meta_ff;
        end
    end
endmodule

// ==== test/dbp_port_sva.sv ====
// Checker for the bus handshake and pin side effects of the pin port.
`timescale 1ns/100ps
module dbp_port_sva #(
    parameter int BIT_IN_CYC = 5,
    parameter int BIT_IN11_CYC = 5,
    parameter int BIT_OUT_SLOW_CYC = 5,
    parameter int BIT_OUT_CYC = 5,
    parameter int BYTE_IN_CYC = 5,
    parameter int BYTE_OUT_CYC = 5
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [11:0] pinIn,
    input wire dbp_pkg::dbp_pins_t pins
);
    // Longest output delay plus slack for the bus cycles.
    localparam int BITMAX = BIT_OUT_SLOW_CYC > BIT_OUT_CYC ?
        BIT_OUT_SLOW_CYC : BIT_OUT_CYC;
    localparam int LIM = 4 + (BITMAX > BYTE_OUT_CYC ?
        BITMAX : BYTE_OUT_CYC);
    logic acc; // First access cycle of a transfer.
    logic ctlWr; // Control write taken.
    logic cfgWr; // Control or direction write taken.
    logic [15:0] sinceWr_ff; // Cycles since the last write.
    assign acc = psel && penable && !pready;
    assign ctlWr = acc && pwrite && paddr == dbp_pkg::OFF_CTRL;
    assign cfgWr = ctlWr || (acc && pwrite && paddr == dbp_pkg::OFF_DIR);
    // Saturates, so a long idle spell never wraps to a small count.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sinceWr_ff <= 16'hffff;
        end else if (acc && pwrite) begin
            sinceWr_ff <= 16'h0000;
        end else if (sinceWr_ff != 16'hffff) begin
            sinceWr_ff <= sinceWr_ff + 16'h0001;
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    AST_ONE_WAIT: assert property (acc |=> pready)
        else $error("no answer after one wait state");
    AST_PULSE: assert property (pready |=> !pready)
        else $error("ready held too long");
    AST_ERR_QUAL: assert property (pslverr |-> pready)
        else $error("error without ready");
    AST_UNMAPPED: assert property (acc && paddr > 8'h18 |=> pslverr)
        else $error("unmapped access accepted");
    AST_PULL_GROUP: assert property (!(|(pins.pullEn & 12'h70f)))
        else $error("pull-up outside its group");
    AST_PULL_CAUSE: assert property ($changed(pins.pullEn) |->
        $past(ctlWr) || $past(ctlWr, 2)) else $error("pull-up moved alone");
    AST_DIR_CAUSE: assert property ($changed(pins.oe) |->
        $past(cfgWr) || $past(cfgWr, 2)) else $error("direction moved alone");
    AST_OUT_CAUSE: assert property ($changed(pins.out) |->
        sinceWr_ff <= LIM) else $error("output moved without request");
endmodule

// ==== test/dbp_ext.sv ====
// Model of the external logic wired to the port's pins.
`timescale 1ns/100ps
module dbp_ext (
    input wire logic mclk,
    input wire dbp_pkg::dbp_pins_t pins,
    input wire logic [11:0] extLvl,
    input wire logic [11:0] extEn,
    output logic [11:0] pinIn
);
    logic [11:0] last_ff = 12'h000; // Last held level of each pin.
    logic [11:0] held; // Pins that either side drives now.
    assign held = pins.oe | extEn;
    // Only a held pin updates its memory, so a released pin keeps one
    // steady level instead of toggling every clock.
    always_ff @(posedge mclk) begin
        last_ff <= (pinIn & held) | (last_ff & ~held);
    end
    // Port drive wins, then the outside source, then the pull-up; a pin
    // nobody holds or pulls shows the inverse of its last level, never a stale one.
    always_comb begin
        for (int i = 0; i < 12; i++) begin
            if (pins.oe[i]) begin
                pinIn[i] = pins.out[i];
            end else if (extEn[i]) begin
                pinIn[i] = extLvl[i];
            end else begin
                pinIn[i] = pins.pullEn[i] | ~last_ff[i];
            end
        end
    end
endmodule

// ==== test/tb.sv ====
// Self-checking bench for the direct pin port.
`timescale 1ns/100ps
module tb;
    localparam int BOS = 12; // Slow bit output delay in cycles.
    localparam int BO = 6; // Other bit output delay in cycles.
    localparam int YO = 8; // Byte output delay in cycles.
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [11:0] pinIn;
    logic [11:0] extLvl = 12'h000; // Level the outside drives.
    logic [11:0] extEn = 12'h000; // Pins the outside drives.
    dbp_pkg::dbp_pins_t pins;
    logic [31:0] rdV; // Read data of the last transfer.
    logic errV; // Error flag of the last transfer.
    logic lv; // Pin level before the flip in a read test.
    int bl; // Expected bit output delay of the pin under test.
    int mismatches = 0;
    int comparisons = 0;
    dbp_port #(.BIT_IN_CYC(6), .BIT_IN11_CYC(3), .BIT_OUT_SLOW_CYC(BOS),
        .BIT_OUT_CYC(BO), .BYTE_IN_CYC(10), .BYTE_OUT_CYC(YO)) dbp_port_inst (
        .mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pinIn(pinIn), .pins(pins));
    dbp_ext dbp_ext_inst (.mclk(mclk), .pins(pins), .extLvl(extLvl),
        .extEn(extEn), .pinIn(pinIn));
    initial begin
        forever #2 mclk = ~mclk;
    end
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp,
        input string m);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t %s: got %h exp %h", $time, m, got, exp);
        end
    endtask
    // One transfer; answer taken at the edge that samples pready high.
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        cmp(pready, 1'b1, "no ready");
        rdV = prdata;
        errV = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Polls the status word until the port is no longer busy.
    task automatic idle();
        int k;
        k = 0;
        do begin
            apb(1'b0, dbp_pkg::OFF_STATUS, 32'h0);
            k++;
        end while (rdV[9] !== 1'b0 && k < 60);
        cmp(rdV[9], 1'b0, "busy stuck");
    endtask
    // Counts cycles until the masked outputs reach the expected levels.
    task automatic waitOut(input logic [11:0] m, input logic [11:0] e,
        input int lat);
        int n;
        n = 0;
        while ((pins.out & m) !== e && n < 60) begin
            @(negedge mclk);
            n++;
        end
        cmp(pins.out & m, e, "output level");
        cmp(n, lat, "output delay");
        idle();
    endtask
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        #200000;
        mismatches++;
        $display("[ERR] %0t watchdog expired", $time);
        final_report();
    end
    initial begin
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        apb(1'b0, dbp_pkg::OFF_DIR, 32'h0);
        cmp(rdV[11:0], dbp_pkg::DIR_RST, "dir reset");
        apb(1'b1, dbp_pkg::OFF_CTRL, 32'h8);
        apb(1'b1, dbp_pkg::OFF_DIR, 32'hfff);
        @(negedge mclk);
        cmp({pins.out, pins.pullEn}, 32'h0, "init default");
        cmp(pins.oe, 12'hfff, "all outputs");
        $display("test reset done");
        for (int p = 0; p < 12; p++) begin
            bl = (p inside {3, 4, 5, 11}) ? BOS : BO;
            apb(1'b1, dbp_pkg::OFF_BITREQ, {16'h0, 8'(p + 1), 4'h1, 4'(p)});
            waitOut(12'(1 << p), 12'(1 << p), bl);
            apb(1'b1, dbp_pkg::OFF_BITREQ, {24'h0, 4'h1, 4'(p)});
            waitOut(12'(1 << p), 12'h0, bl);
        end
        apb(1'b1, dbp_pkg::OFF_BITREQ, {16'h0, 8'h01, 4'h1, 4'hc});
        apb(1'b0, dbp_pkg::OFF_STATUS, 32'h0);
        cmp(rdV[9], 1'b0, "pin twelve refused");
        cmp(pins.out, 12'h0, "pin twelve ignored");
        apb(1'b1, dbp_pkg::OFF_DIR, 32'h0);
        extEn <= 12'hfff;
        extLvl <= 12'ha5c;
        for (int p = 0; p < 12; p++) begin
            apb(1'b1, dbp_pkg::OFF_BITREQ, {28'h0, 4'(p)});
            // Flip the pin just after the request: the short pin-eleven
            // delay samples the old level, the long one the new level.
            lv = extLvl[p];
            extLvl[p] <= ~lv;
            idle();
            cmp(rdV[8], 1'b1, "read done");
            cmp(rdV[7:0], {7'h0, (p == 11) ? lv : ~lv}, "bit in");
        end
        apb(1'b1, dbp_pkg::OFF_DIR, 32'h5a5);
        @(negedge mclk);
        cmp(pins.oe, 12'h5a5, "mixed directions");
        $display("test bits done");
        apb(1'b1, dbp_pkg::OFF_CTRL, 32'hc);
        repeat (2) @(negedge mclk);
        cmp(pins.pullEn, 12'h8f0, "pull request");
        apb(1'b1, dbp_pkg::OFF_CTRL, 32'ha);
        repeat (2) @(negedge mclk);
        cmp(pins.pullEn, 12'h0f0, "self test pulls");
        apb(1'b1, dbp_pkg::OFF_INIT, 32'h5a3);
        apb(1'b1, dbp_pkg::OFF_CTRL, 32'h8);
        repeat (2) @(negedge mclk);
        cmp({pins.out, pins.pullEn}, 24'h5a3000, "init levels");
        apb(1'b1, dbp_pkg::OFF_CTRL, 32'h1);
        apb(1'b1, dbp_pkg::OFF_DIR, 32'h1);
        @(negedge mclk);
        cmp(pins.oe[7:0], 8'hff, "byte drive");
        apb(1'b1, dbp_pkg::OFF_BYTEREQ, 32'h196);
        waitOut(12'hfff, 12'h596, YO);
        apb(1'b1, dbp_pkg::OFF_CTRL, 32'h9);
        repeat (2) @(negedge mclk);
        cmp(pins.out, 12'h5a3, "byte init");
        apb(1'b1, dbp_pkg::OFF_DIR, 32'h0);
        extLvl <= 12'h0c3;
        apb(1'b1, dbp_pkg::OFF_BYTEREQ, 32'h0);
        apb(1'b1, dbp_pkg::OFF_BYTEREQ, 32'h0);
        cmp(errV, 1'b1, "busy refusal");
        idle();
        cmp(rdV[7:0], 8'hc3, "byte in");
        apb(1'b1, dbp_pkg::OFF_CTRL, 32'h0);
        apb(1'b1, dbp_pkg::OFF_BYTEREQ, 32'h155);
        repeat (20) @(negedge mclk);
        cmp(pins.out, 12'h5a3, "byte off ignored");
        apb(1'b0, 8'h1c, 32'h0);
        cmp(errV, 1'b1, "unmapped");
        $display("test byte done");
        final_report();
    end
endmodule
bind dbp_port dbp_port_sva #(.BIT_IN_CYC(BIT_IN_CYC),
    .BIT_IN11_CYC(BIT_IN11_CYC), .BIT_OUT_SLOW_CYC(BIT_OUT_SLOW_CYC),
    .BIT_OUT_CYC(BIT_OUT_CYC), .BYTE_IN_CYC(BYTE_IN_CYC),
    .BYTE_OUT_CYC(BYTE_OUT_CYC)) dbp_port_sva_inst (.mclk(mclk),
    .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pinIn(pinIn), .pins(pins));
